// File: core/irqeb_bank.sv
// interrupt request flag and enable bank with apb register access
// Behaviour
// - uart a flag bit7, enable bit3
// - serial module flag bit6, enable bit2
// - pin b flag bit5, enable bit1
// - timebase b flag bit4, enable bit0
// - pin c flag bit5, enable bit1
// - uart b flag bit4, enable bit0
// - unimplemented bits always read zero
// - periodic timer b A/P flags bits 7,6
// - std timer P/A flags bits 4,5
// - compact timer A/P enables bits 3,2
// - compact P enable gates only P
// - periodic timer a P flag4, enable0
// - periodic timer a A enable bit1
// - nv data write flag5, enable1
// - low voltage flag4, enable0
// - global enable gates every IRQ_REQ bit, not MF_SUMMARY (timer group a, timer group b, nv write/low voltage) or WAKE_REQ
// - event sets flag regardless of enable
// - any set flag requests wake
`timescale 1ns/1ns
`default_nettype none
module irqeb_bank (
  input wire logic CLOCK,             // system clock, 25 MHz
  input wire logic RSTN,              // sync reset, active low
  input wire logic PSEL,              // apb select
  input wire logic PENABLE,           // apb access phase
  input wire logic PWRITE,            // apb direction
  input wire logic [11:0] PADDR,      // apb byte address
  input wire logic [31:0] PWDATA,     // apb write data
  output logic [31:0] PRDATA,         // apb read data
  output logic PREADY,                // apb ready
  output logic PSLVERR,               // apb error, unmapped
  input wire logic [3:0] EVT_SERIAL,  // uart a, serial, pin b, tb b
  input wire logic [1:0] EVT_UARTB_PINC, // pin c, uart b
  input wire logic [3:0] EVT_TMR_A,   // ptb A, ptb P, std A, std P
  input wire logic [3:0] EVT_TMR_B,   // ct A, ct P, pta A, pta P
  input wire logic [1:0] EVT_NVM_LV,  // nv write, low voltage
  input wire logic ISR_ENTRY,         // core entered a service routine
  output logic [13:0] IRQ_REQ,        // gated requests to the core
  output logic [2:0] MF_SUMMARY,      // multi-function summaries
  output logic GLOBAL_EN,             // global enable state
  output logic WAKE_REQ               // wake from sleep or idle
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic global_irq_enable;
    logic [31:0] rdata;
  } irqeb_top_s;
  irqeb_top_s st_q;
  irqeb_top_s st_d;

  logic [7:0] r_val [irqeb_pkg::NUM_REGS];
  logic [3:0] r_pend [irqeb_pkg::NUM_REGS];
  logic [3:0] r_evt [irqeb_pkg::NUM_REGS];
  logic [11:0] r_off [irqeb_pkg::NUM_REGS];
  logic [7:0] r_mask [irqeb_pkg::NUM_REGS];
  logic [irqeb_pkg::NUM_REGS-1:0] r_wr;
  logic wr_access;
  logic rd_access;
  logic mapped;
  logic [7:0] flags_any;

  // ****************************************************************
  // event routing into the five registers
  // ****************************************************************
  // uart a, serial, pin b, timebase b
  assign r_evt[0] = EVT_SERIAL;
  // pin c in bit 5, uart b in bit 4
  assign r_evt[1] = {2'h0, EVT_UARTB_PINC};
  // timer group a flags in bits 7..4
  // std timer flags bits 5, 4
  assign r_evt[2] = EVT_TMR_A;
  assign r_evt[3] = EVT_TMR_B;
  // nv write in bit 5, low voltage in bit 4
  assign r_evt[4] = {2'h0, EVT_NVM_LV};
  assign r_off[0] = irqeb_pkg::OFF_SERIAL_TIME_PIN;
  assign r_off[1] = irqeb_pkg::OFF_UART_B_PIN_C;
  assign r_off[2] = irqeb_pkg::OFF_TIMER_GROUP_A;
  assign r_off[3] = irqeb_pkg::OFF_TIMER_GROUP_B;
  assign r_off[4] = irqeb_pkg::OFF_NVM_LOWVOLT;
  assign r_mask[0] = irqeb_pkg::MASK_FULL;
  assign r_mask[1] = irqeb_pkg::MASK_HALF;
  assign r_mask[2] = irqeb_pkg::MASK_FULL;
  assign r_mask[3] = irqeb_pkg::MASK_FULL;
  assign r_mask[4] = irqeb_pkg::MASK_HALF;

  // ****************************************************************
  // apb decode, zero wait states
  // ****************************************************************
  assign wr_access = PSEL && PENABLE && PWRITE;
  assign rd_access = PSEL && !PENABLE && !PWRITE;

  // one register instance per flag/enable word, five in all; global control and summary have none
  genvar gi;
  generate
    for (gi = 0; gi < irqeb_pkg::NUM_REGS; gi++) begin : g_reg
      assign r_wr[gi] = wr_access && (PADDR == r_off[gi]);
      irqeb_reg #(
        .IMPL_MASK((gi == 1 || gi == 4) ? irqeb_pkg::MASK_HALF
                                       : irqeb_pkg::MASK_FULL)
      ) u_reg (
        .clk(CLOCK),
        .rst_n(RSTN),
        .wr_en(r_wr[gi]),
        .wr_data(PWDATA[7:0]),
        .event_set(r_evt[gi]),
        .value(r_val[gi]),
        .pending(r_pend[gi])
      );
    end
  endgenerate

  // address map check
  always_comb begin
    mapped = 1'b0;
    for (int i = 0; i < irqeb_pkg::NUM_REGS; i++) begin
      if (PADDR == r_off[i]) begin
        mapped = 1'b1;
      end
    end
    if (PADDR == irqeb_pkg::OFF_GLOBAL_CTRL ||
        PADDR == irqeb_pkg::OFF_SUMMARY) begin
      mapped = 1'b1;
    end
  end

  // ****************************************************************
  // next state: global enable and read data
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    // global enable, cleared on service entry
    if (ISR_ENTRY) begin
      st_d.global_irq_enable = 1'b0;
    end
    if (wr_access && PADDR == irqeb_pkg::OFF_GLOBAL_CTRL) begin
      st_d.global_irq_enable = PWDATA[0];
    end
    // read data captured in setup, stable during access
    if (rd_access) begin
      st_d.rdata = 32'h0000_0000;
      for (int i = 0; i < irqeb_pkg::NUM_REGS; i++) begin
        if (PADDR == r_off[i]) begin
          st_d.rdata = {24'h00_0000, r_val[i] & r_mask[i]};
        end
      end
      if (PADDR == irqeb_pkg::OFF_GLOBAL_CTRL) begin
        st_d.rdata = {31'h0000_0000, st_q.global_irq_enable};
      end
      if (PADDR == irqeb_pkg::OFF_SUMMARY) begin
        st_d.rdata = {28'h000_0000, WAKE_REQ, MF_SUMMARY};
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      st_q.global_irq_enable <= irqeb_pkg::GLOBAL_RESET;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign PRDATA = st_q.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign GLOBAL_EN = st_q.global_irq_enable;

  assign MF_SUMMARY[irqeb_pkg::SUM_GROUP_A] = |r_pend[2];
  assign MF_SUMMARY[irqeb_pkg::SUM_GROUP_B] = |r_pend[3];
  assign MF_SUMMARY[irqeb_pkg::SUM_NVM_LV] = |r_pend[4];

  // compact A and P enables separate
  // requests gated by global enable; per-pair gating
  assign IRQ_REQ = {14{st_q.global_irq_enable}} &
    {r_pend[0], r_pend[1][1:0], r_pend[2], r_pend[3]};

  // any set flag wakes the device
  always_comb begin
    flags_any = 8'h00;
    for (int i = 0; i < irqeb_pkg::NUM_REGS; i++) begin
      flags_any = flags_any | (r_val[i] & r_mask[i] & 8'hF0);
    end
  end
  assign WAKE_REQ = |flags_any;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_global_gates_all: assert property (@(posedge CLOCK)
    disable iff (!RSTN) !GLOBAL_EN |-> IRQ_REQ == 14'h0000)
    else $error("request with global enable low");
  a_compact_p_only: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    (r_val[3][6] && r_val[3][2] && GLOBAL_EN) |-> IRQ_REQ[2])
    else $error("compact P request not gated through");
  a_compact_p_off: assert property (@(posedge CLOCK)
    disable iff (!RSTN) (r_val[3][6] && !r_val[3][2]) |-> !IRQ_REQ[2])
    else $error("compact P request without its enable");
  a_unimpl_read_zero: assert property (@(posedge CLOCK)
    disable iff (!RSTN) (rd_access && PADDR == irqeb_pkg::OFF_NVM_LOWVOLT)
    |=> (PRDATA[7:6] == 2'h0 && PRDATA[3:2] == 2'h0))
    else $error("unimplemented bits read nonzero");
  a_event_no_enable: assert property (@(posedge CLOCK)
    disable iff (!RSTN) EVT_SERIAL[3] |=> r_val[0][7])
    else $error("uart a flag not set by event");
  a_summary_lv: assert property (@(posedge CLOCK)
    disable iff (!RSTN) (r_val[4][4] && r_val[4][0]) |-> MF_SUMMARY[2])
    else $error("summary missing low voltage");
  a_summary_group_a: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    MF_SUMMARY[0] == ((r_val[2][7:4] & r_val[2][3:0]) != 4'h0))
    else $error("timer group a summary wrong");
  a_summary_group_b: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    MF_SUMMARY[1] == ((r_val[3][7:4] & r_val[3][3:0]) != 4'h0))
    else $error("timer group b summary wrong");
  a_wake_on_flag: assert property (@(posedge CLOCK)
    disable iff (!RSTN) r_val[1][5] |-> WAKE_REQ)
    else $error("no wake on pin c flag");
  a_wake_any_flag: assert property (@(posedge CLOCK)
    disable iff (!RSTN) WAKE_REQ == (((r_val[0] | r_val[1] | r_val[2] |
    r_val[3] | r_val[4]) & 8'hF0) != 8'h00))
    else $error("wake request does not match the flags");
  a_write_takes: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    (wr_access && PADDR == irqeb_pkg::OFF_TIMER_GROUP_B && EVT_TMR_B == 4'h0)
    |=> r_val[3] == $past(PWDATA[7:0]))
    else $error("write to timer group b lost");
  a_isr_clears_ge: assert property (@(posedge CLOCK)
    disable iff (!RSTN) (ISR_ENTRY && !wr_access) |=> !GLOBAL_EN)
    else $error("global enable not cleared on entry");
  a_global_write: assert property (@(posedge CLOCK)
    disable iff (!RSTN) (wr_access && PADDR == irqeb_pkg::OFF_GLOBAL_CTRL)
    |=> GLOBAL_EN == $past(PWDATA[0]))
    else $error("global enable write lost");
  a_reset_clears: assert property (@(posedge CLOCK)
    (RSTN && !$past(RSTN)) |-> (!GLOBAL_EN && PRDATA == 32'h0000_0000 &&
    (r_val[0] | r_val[1] | r_val[2] | r_val[3] | r_val[4]) == 8'h00))
    else $error("state not clear after reset");
  a_uart_a_gated: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[13] == (GLOBAL_EN && r_val[0][7] && r_val[0][3]))
    else $error("uart a request misrouted");
  a_serial_gated: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[12] == (GLOBAL_EN && r_val[0][6] && r_val[0][2]))
    else $error("serial module request misrouted");
  a_pin_b_gated: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[11] == (GLOBAL_EN && r_val[0][5] && r_val[0][1]))
    else $error("pin b request misrouted");
  a_timebase_b_gated: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[10] == (GLOBAL_EN && r_val[0][4] && r_val[0][0]))
    else $error("timebase b request misrouted");
  a_pin_c_gated: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[9] == (GLOBAL_EN && r_val[1][5] && r_val[1][1]))
    else $error("pin c request misrouted");
  a_uart_b_gated: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[8] == (GLOBAL_EN && r_val[1][4] && r_val[1][0]))
    else $error("uart b request misrouted");
  a_ptimer_b_pair: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[7:6] == ({2{GLOBAL_EN}} & r_val[2][7:6] & r_val[2][3:2]))
    else $error("periodic timer b requests misrouted");
  a_std_timer_pair: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[5:4] == ({2{GLOBAL_EN}} & r_val[2][5:4] & r_val[2][1:0]))
    else $error("std timer requests misrouted");
  a_compact_a_gated: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[3] == (GLOBAL_EN && r_val[3][7] && r_val[3][3]))
    else $error("compact A request misrouted");
  a_ptimer_a_p: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[0] == (GLOBAL_EN && r_val[3][4] && r_val[3][0]))
    else $error("periodic timer a P request misrouted");
  a_ptimer_a_a: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    IRQ_REQ[1] == (GLOBAL_EN && r_val[3][5] && r_val[3][1]))
    else $error("periodic timer a A request misrouted");
  a_nvdata_summary: assert property (@(posedge CLOCK)
    disable iff (!RSTN) (r_val[4][5] && r_val[4][1]) |-> MF_SUMMARY[2])
    else $error("summary missing nv write");
  a_lowvolt_alone: assert property (@(posedge CLOCK)
    disable iff (!RSTN)
    (r_val[4][4] && !r_val[4][0] && !r_val[4][1]) |-> !MF_SUMMARY[2])
    else $error("low voltage summary without its enable");
endmodule : irqeb_bank
`default_nettype wire

// File: core/irqeb_pkg.sv
// package of offsets, field positions and reset values for the request bank
package irqeb_pkg;
  // ****************************************************************
  // register word offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFF_SERIAL_TIME_PIN = 12'h000;
  localparam logic [11:0] OFF_UART_B_PIN_C = 12'h004;
  localparam logic [11:0] OFF_TIMER_GROUP_A = 12'h008;
  localparam logic [11:0] OFF_TIMER_GROUP_B = 12'h00C;
  localparam logic [11:0] OFF_NVM_LOWVOLT = 12'h010;
  localparam logic [11:0] OFF_GLOBAL_CTRL = 12'h014;
  localparam logic [11:0] OFF_SUMMARY = 12'h018;
  localparam int NUM_REGS = 5;
  // ****************************************************************
  // field layout: flags in bits 7..4, enables in bits 3..0
  // ****************************************************************
  localparam int FLAG_LSB = 4;
  localparam int PAIR_COUNT = 4;
  // implemented-bit masks; unimplemented bits read as zero
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_HALF = 8'h33;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic GLOBAL_RESET = 1'h0;
  // summary output bit positions
  localparam int SUM_GROUP_A = 0;
  localparam int SUM_GROUP_B = 1;
  localparam int SUM_NVM_LV = 2;
endpackage : irqeb_pkg

// File: core/irqeb_reg.sv
// one 8-bit flag/enable register with event set and software write
`timescale 1ns/1ns
`default_nettype none
module irqeb_reg #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input wire logic clk,              // system clock
  input wire logic rst_n,            // sync reset, active low
  input wire logic wr_en,            // software write strobe
  input wire logic [7:0] wr_data,    // software write data
  input wire logic [3:0] event_set,  // per-pair event pulses
  output logic [7:0] value,          // register contents
  output logic [3:0] pending         // flag and enable per pair
);
  typedef struct packed {
    logic [7:0] bits;
  } irqeb_reg_s;
  irqeb_reg_s st_q;
  irqeb_reg_s st_d;

  // software write, then hardware set wins over a clear
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.bits = wr_data;
    end
    // flags set even while the enable is low
    st_d.bits[7:4] = st_d.bits[7:4] | event_set;
    st_d.bits = st_d.bits & IMPL_MASK;
  end

  // state register, cleared on reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q.bits <= irqeb_pkg::REG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign value = st_q.bits;
  // each enable gates only its own flag
  assign pending = st_q.bits[7:4] & st_q.bits[3:0];

  // ****************************************************************
  // checks
  // ****************************************************************
  a_event_sets_flag: assert property (@(posedge clk)
    disable iff (!rst_n) (event_set[0] && IMPL_MASK[4]) |=> value[4])
    else $error("event did not set its flag");
  a_set_beats_clear: assert property (@(posedge clk)
    disable iff (!rst_n) (wr_en && event_set != 4'h0) |=>
    ((value[7:4] & $past(event_set) & IMPL_MASK[7:4]) ==
    ($past(event_set) & IMPL_MASK[7:4])))
    else $error("event lost against a software write");
  a_unimpl_zero: assert property (@(posedge clk)
    disable iff (!rst_n) (value & ~IMPL_MASK) == 8'h00)
    else $error("unimplemented bit not zero");
endmodule : irqeb_reg
`default_nettype wire

// File: dv/irqeb_src_model.sv
// peripheral event sources and core entry strobe for the request bank
`timescale 1ns/1ns
`default_nettype none
module irqeb_src_model (
  input wire logic fire,              // one-cycle event strobe
  input wire logic [15:0] which,      // sources that raise an event
  input wire logic isr,               // core enters a service routine
  output logic [3:0] evt_serial,      // uart a, serial, pin b, tb b
  output logic [1:0] evt_uartb_pinc,  // pin c, uart b
  output logic [3:0] evt_tmr_a,       // timer group a events
  output logic [3:0] evt_tmr_b,       // timer group b events
  output logic [1:0] evt_nvm_lv,      // nv write, low voltage
  output logic isr_entry              // service entry pulse
);
  assign {evt_serial, evt_uartb_pinc, evt_tmr_a, evt_tmr_b,
          evt_nvm_lv} = fire ? which : 16'h0000;
  // core entry strobe passes straight through
  assign isr_entry = isr;
endmodule : irqeb_src_model
`default_nettype wire

// File: dv/test_irqeb_bank.sv
// self-checking bench for the request flag and enable bank
`timescale 1ns/1ns
`default_nettype none
module test_irqeb_bank;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic fire = 1'b0;
  logic isr = 1'b0;
  logic [15:0] which = 16'h0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, global_en, wake_req, isr_entry, err;
  logic [3:0] evt_serial, evt_tmr_a, evt_tmr_b;
  logic [1:0] evt_uartb_pinc, evt_nvm_lv;
  logic [13:0] irq_req;
  logic [2:0] mf_summary;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  irqeb_bank dut (.CLOCK(clock), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EVT_SERIAL(evt_serial), .EVT_UARTB_PINC(evt_uartb_pinc),
    .EVT_TMR_A(evt_tmr_a), .EVT_TMR_B(evt_tmr_b), .EVT_NVM_LV(evt_nvm_lv),
    .ISR_ENTRY(isr_entry), .IRQ_REQ(irq_req), .MF_SUMMARY(mf_summary),
    .GLOBAL_EN(global_en), .WAKE_REQ(wake_req));

  irqeb_src_model src (.fire(fire), .which(which), .isr(isr),
    .evt_serial(evt_serial), .evt_uartb_pinc(evt_uartb_pinc),
    .evt_tmr_a(evt_tmr_a), .evt_tmr_b(evt_tmr_b),
    .evt_nvm_lv(evt_nvm_lv), .isr_entry(isr_entry));

  // ******************************
  // clock, timeout and reporting
  // ******************************
  initial begin
    forever #20 clock = ~clock;
  end

  // cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, read data and error kept in rd and err
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle event and entry strobes, outputs settled on return
  task automatic pulse(input logic [15:0] w, input logic i);
    @(posedge clock);
    fire <= |w;
    which <= w;
    isr <= i;
    @(posedge clock);
    fire <= 1'b0;
    isr <= 1'b0;
    @(negedge clock);
  endtask : pulse

  // flag byte each register should show for a set of events
  function automatic logic [7:0] flags_of(int i, logic [15:0] w);
    case (i)
      0: return {w[15:12], 4'h0};
      1: return {2'b00, w[11:10], 4'h0};
      2: return {w[9:6], 4'h0};
      3: return {w[5:2], 4'h0};
      default: return {2'b00, w[1:0], 4'h0};
    endcase
  endfunction : flags_of

  // ******************************
  // test sequence
  // ******************************
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    $display("test reset values done");
    // write ones, unused bits stay zero
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'(i * 4), 32'hFFFF_FFFF);
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, {24'h0, (i == 1 || i == 4) ? 8'h33 : 8'hFF});
      apb(1'b1, 12'(i * 4), 32'h0);
    end
    $display("test implemented bits done");
    // each source sets only its flag
    for (int b = 0; b < 17; b++) begin
      pulse((b < 16) ? 16'(1 << b) : 16'hFFFF, 1'b0);
      if (b == 16) begin
        chk({18'h0, irq_req}, 32'h0);
        chk({31'h0, wake_req}, 32'h1);
        chk({29'h0, mf_summary}, 32'h0);
      end
      for (int i = 0; i < 5; i++) begin
        apb(1'b0, 12'(i * 4), 32'h0);
        chk(rd, {24'h0, flags_of(i, (b < 16) ? 16'(1 << b) : 16'hFFFF)});
        apb(1'b1, 12'(i * 4), 32'h0);
      end
    end
    $display("test flag positions done");
    // compact P enable gates P alone
    for (int i = 0; i < 5; i++) apb(1'b1, 12'(i * 4), 32'hFF);
    apb(1'b1, irqeb_pkg::OFF_TIMER_GROUP_B, 32'hF4);
    apb(1'b1, irqeb_pkg::OFF_GLOBAL_CTRL, 32'h1);
    @(negedge clock);
    chk({18'h0, irq_req}, 32'h3FF4);
    chk({29'h0, mf_summary}, 32'h7);
    apb(1'b0, irqeb_pkg::OFF_SUMMARY, 32'h0);
    chk(rd, 32'hF);
    chk({31'h0, err}, 32'h0);
    pulse(16'h0000, 1'b1);
    chk({31'h0, global_en}, 32'h0);
    chk({18'h0, irq_req}, 32'h0);
    chk({29'h0, mf_summary}, 32'h7);
    $display("test gating done");
    apb(1'b0, 12'h01C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule : test_irqeb_bank
`default_nettype wire
